// ---- rtl/pwm_channel_pkg.sv ----
// What this block does
// - centre aligned: count up, down, zero ends
// - left aligned: count up, reset ends period
// - alignment selectable, left after reset
// - start level selectable, low after reset
// - fixed low at full duty/low or zero/high
// - fixed high at zero/low or full/high
// - start level writes only while disabled
// - direct period/duty writes only while disabled
// - update value waits for period end
// - update target picks period or duty
// - counting tick: prescaled, divided a or b
// - enables in one write start together
// - interrupt enable gates period event
package pwm_channel_pkg;

    // ---------------------------------------------------------------
    // widths
    // ---------------------------------------------------------------
    localparam int unsigned COUNT_WIDTH    = 16;
    localparam int unsigned SELECT_WIDTH   = 4;
    localparam int unsigned PRESCALE_WIDTH = 10;

    // ---------------------------------------------------------------
    // encodings
    // ---------------------------------------------------------------
    localparam logic [SELECT_WIDTH-1:0] SEL_PRESCALE_MAX = 4'ha;
    localparam logic [SELECT_WIDTH-1:0] SEL_DIVIDED_A    = 4'hb;
    localparam logic [SELECT_WIDTH-1:0] SEL_DIVIDED_B    = 4'hc;
    localparam logic                    ALIGN_LEFT       = 1'b0;
    localparam logic                    ALIGN_CENTRE     = 1'b1;
    localparam logic                    LEVEL_LOW        = 1'b0;
    localparam logic                    TARGET_DUTY      = 1'b0;
    localparam logic                    TARGET_PERIOD    = 1'b1;
    localparam logic [PRESCALE_WIDTH-1:0] PRESCALE_ONES  = 10'h3ff;

    // ---------------------------------------------------------------
    // counter direction
    // ---------------------------------------------------------------
    typedef enum logic [0:0]
    {
        DIR_UP   = 1'b0,
        DIR_DOWN = 1'b1
    } count_dir_t;

endpackage

// ---- rtl/pwm_channel_waveform.sv ----
`timescale 1ns/1ps
module pwm_channel_waveform
#(
    parameter int unsigned WIDTH = pwm_channel_pkg::COUNT_WIDTH
)
(
    // clock and reset
    input  wire logic                                      i_clock,
    input  wire logic                                      i_reset_n,
    input  wire logic                                      i_clock_enable,
    // divided clock ticks, one-cycle pulses on i_clock
    input  wire logic                                      i_divided_clock_a,
    input  wire logic                                      i_divided_clock_b,
    // direct period and duty writes
    input  wire logic [WIDTH-1:0]                          i_period_value,
    input  wire logic                                      i_period_write,
    input  wire logic [WIDTH-1:0]                          i_duty_value,
    input  wire logic                                      i_duty_write,
    // update value write
    input  wire logic [WIDTH-1:0]                          i_channel_update_value,
    input  wire logic                                      i_update_write,
    // channel mode settings write
    input  wire logic                                      i_mode_write,
    input  wire logic                                      i_alignment_select,
    input  wire logic                                      i_start_level_select,
    input  wire logic                                      i_update_target_select,
    input  wire logic [pwm_channel_pkg::SELECT_WIDTH-1:0]  i_channel_clock_select,
    // enable and interrupt enable strobes
    input  wire logic                                      i_enable_write,
    input  wire logic                                      i_disable_write,
    input  wire logic                                      i_irq_enable_write,
    input  wire logic                                      i_irq_disable_write,
    // waveform
    output logic                                           o_pwm,
    // status
    output logic                                           o_enabled,
    output logic                                           o_irq_enabled,
    output logic                                           o_update_pending,
    output logic [WIDTH-1:0]                               o_counter,
    output logic                                           o_period_irq
);
    import pwm_channel_pkg::*;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed
    {
        logic [PRESCALE_WIDTH-1:0] prescale;
        logic [WIDTH-1:0]          counter;
        count_dir_t                dir;
        logic [WIDTH-1:0]          period;
        logic [WIDTH-1:0]          duty;
        logic [WIDTH-1:0]          update;
        logic                      pending;
        logic                      target;
        logic                      align;
        logic                      level;
        logic [SELECT_WIDTH-1:0]   clk_sel;
        logic                      enabled;
        logic                      irq_en;
        logic                      out;
        logic                      irq;
    } state_t;

    state_t                    q;
    state_t                    d;
    logic                      tick;
    logic                      end_period;
    logic [PRESCALE_WIDTH-1:0] mask;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb
    begin
        d          = q;
        d.irq      = 1'b0;
        end_period = 1'b0;
        d.prescale = q.prescale + 1'b1;
        mask       = ~(PRESCALE_ONES << q.clk_sel);
        if (q.clk_sel == SEL_DIVIDED_A)
        begin
            tick = i_divided_clock_a;
        end
        else if (q.clk_sel == SEL_DIVIDED_B)
        begin
            tick = i_divided_clock_b;
        end
        else if (q.clk_sel <= SEL_PRESCALE_MAX)
        begin
            tick = ((q.prescale & mask) == mask);
        end
        else
        begin
            tick = 1'b0;
        end
        if (i_period_write && !q.enabled)
        begin
            d.period = i_period_value;
        end
        if (i_duty_write && !q.enabled)
        begin
            d.duty = i_duty_value;
        end
        if (i_mode_write)
        begin
            d.align   = i_alignment_select;
            d.target  = i_update_target_select;
            d.clk_sel = i_channel_clock_select;
            if (!q.enabled)
            begin
                d.level = i_start_level_select;
            end
        end
        if (q.enabled && tick)
        begin
            if (q.align == ALIGN_CENTRE)
            begin
                // up to period, down to zero
                if (q.dir == DIR_DOWN || (q.counter >= q.period && q.period != '0))
                begin
                    d.counter = q.counter - 1'b1;
                    d.dir     = DIR_DOWN;
                    if (d.counter == '0)
                    begin
                        end_period = 1'b1;
                        d.dir      = DIR_UP;
                    end
                end
                else if (q.counter >= q.period)
                begin
                    end_period = 1'b1;
                end
                else
                begin
                    d.counter = q.counter + 1'b1;
                end
            end
            else
            begin
                d.dir = DIR_UP;
                if (q.counter >= q.period)
                begin
                    d.counter  = '0;
                    end_period = 1'b1;
                end
                else
                begin
                    d.counter = q.counter + 1'b1;
                end
            end
        end
        // pending value lands at period end
        if (end_period)
        begin
            d.irq     = q.irq_en;
            d.pending = 1'b0;
            if (q.pending)
            begin
                if (q.target == TARGET_PERIOD)
                begin
                    d.period = q.update;
                end
                else
                begin
                    d.duty = q.update;
                end
            end
        end
        // a fresh update wins over the clear at period end
        if (i_update_write)
        begin
            d.update  = i_channel_update_value;
            d.pending = 1'b1;
        end
        if (i_irq_disable_write)
        begin
            d.irq_en = 1'b0;
        end
        if (i_irq_enable_write)
        begin
            d.irq_en = 1'b1;
        end
        if (i_enable_write && !q.enabled)
        begin
            d.enabled  = 1'b1;
            d.counter  = '0;
            d.dir      = DIR_UP;
            d.prescale = '0;
        end
        if (i_disable_write)
        begin
            d.enabled = 1'b0;
            d.counter = '0;
            d.dir     = DIR_UP;
            d.pending = 1'b0;
        end
        // disabled output follows the start level at once
        if (!d.enabled || d.duty == d.period)
        begin
            d.out = d.level;
        end
        else if (d.duty == '0)
        begin
            // fixed opposite level at zero duty
            d.out = ~d.level;
        end
        else
        begin
            d.out = (d.counter < d.period - d.duty) ? d.level : ~d.level;
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            q <= state_t'('0);
        end
        else if (i_clock_enable)
        begin
            q <= d;
        end
    end

    assign o_pwm            = q.out;
    assign o_enabled        = q.enabled;
    assign o_irq_enabled    = q.irq_en;
    assign o_update_pending = q.pending;
    assign o_counter        = q.counter;
    assign o_period_irq     = q.irq;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_centre_turn_down: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        i_clock_enable && q.enabled && tick && q.align == ALIGN_CENTRE && q.dir == DIR_UP
        && q.counter >= q.period && q.period > 1 && !i_disable_write && !i_enable_write
        |=> q.dir == DIR_DOWN && q.counter == $past(q.counter) - 1'b1)
        else $error("centre counter did not turn down at period");

    a_left_wrap_zero: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        i_clock_enable && q.enabled && tick && q.align == ALIGN_LEFT
        && q.counter >= q.period && !i_disable_write
        |=> q.counter == '0 && q.dir == DIR_UP)
        else $error("left counter did not wrap at period");

    a_align_reset_left: assert property (
        @(posedge i_clock)
        $rose(i_reset_n) |-> q.align == ALIGN_LEFT && !o_enabled)
        else $error("alignment not left after reset");

    a_idle_level_low: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        i_clock_enable && !q.enabled && q.level == LEVEL_LOW && !i_enable_write && !i_mode_write
        |=> !o_pwm)
        else $error("idle output not at low start level");

    a_fixed_low_out: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        i_clock_enable && ((d.duty == d.period && !d.level)
        || (d.duty == '0 && d.level && d.period != '0 && d.enabled))
        |=> !o_pwm)
        else $error("output not fixed low");

    a_fixed_high_out: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        i_clock_enable && d.enabled && d.period != '0
        && ((d.duty == '0 && !d.level) || (d.duty == d.period && d.level))
        |=> o_pwm)
        else $error("output not fixed high");

    a_level_write_gated: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        i_clock_enable && q.enabled && i_mode_write && !i_disable_write
        |=> q.level == $past(q.level))
        else $error("start level changed while enabled");

    a_direct_write_gated: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        i_clock_enable && q.enabled && (i_period_write || i_duty_write) && !end_period
        |=> $stable(q.period) && $stable(q.duty))
        else $error("direct write taken while enabled");

    a_update_held: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        i_clock_enable && q.enabled && q.pending && !end_period && !i_disable_write
        |=> $stable(q.period) && $stable(q.duty) && q.pending)
        else $error("update applied before period end");

    a_update_target: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        i_clock_enable && end_period && q.pending && !i_disable_write
        |=> (($past(q.target) == TARGET_PERIOD) ? q.period : q.duty) == $past(q.update))
        else $error("update went to the wrong value");

    a_divided_a_tick: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        i_clock_enable && q.enabled && q.clk_sel == SEL_DIVIDED_A && !i_divided_clock_a
        && !i_enable_write && !i_disable_write
        |=> $stable(q.counter))
        else $error("counter moved without divided clock a");

    a_enable_restart: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        i_clock_enable && i_enable_write && !q.enabled && !i_disable_write
        |=> o_enabled && o_counter == '0 && q.prescale == '0)
        else $error("enable did not restart the period");

    a_period_irq_gate: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        i_clock_enable && end_period
        |=> o_period_irq == $past(q.irq_en))
        else $error("period interrupt not gated by its enable");

endmodule

// ---- tb/pwm_load.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// load on the channel pin: counts clock cycles spent high
// ------------------------------------------------------------
module pwm_load
(
    // clock
    input  wire logic        i_clock,
    // pin and control
    input  wire logic        i_pin,
    input  wire logic        i_clear,
    // measurement
    output logic [31:0]      o_high_cycles
);
    always_ff @(posedge i_clock)
    begin
        if (i_clear)
            o_high_cycles <= 32'h0;
        else if (i_pin)
            o_high_cycles <= o_high_cycles + 32'h1;
    end
endmodule

// ---- tb/pwm_channel_waveform_bench.sv ----
`timescale 1ns/1ps
module pwm_channel_waveform_bench;
    import pwm_channel_pkg::*;
    // ------------------------------------------------------------
    // stimulus, observation and reference state
    // ------------------------------------------------------------
    logic        clock = 1'b0, reset_n = 1'b0, ce = 1'b1, div_a = 1'b0, div_b = 1'b0;
    logic        per_wr = 1'b0, duty_wr = 1'b0, upd_wr = 1'b0, mode_wr = 1'b0;
    logic        en_wr = 1'b0, dis_wr = 1'b0, ien_wr = 1'b0, idis_wr = 1'b0, clr = 1'b1;
    logic        align = 1'b0, level = 1'b0, target = 1'b0;
    logic [3:0]  sel = 4'h0;
    logic [15:0] per_val = 16'h0, duty_val = 16'h0, upd_val = 16'h0;
    logic        pwm, enabled, irq_on, pending, irq;
    logic [15:0] counter;
    logic [31:0] high_cycles;
    int          fails = 0, tests_run = 0;
    int          m_cnt = 0, m_p = 0, m_d = 0, m_upd = 0, m_high = 0, irq_exp = 0, irq_seen = 0;
    bit          m_on = 0, m_dir = 0, m_lvl = 0, m_align = 0, m_tgt = 0, m_pend = 0, m_irq = 0;
    int          m_pre = 0;
    logic [3:0]  m_sel = 4'h0;

    always #25 clock = ~clock;

    pwm_channel_waveform pwm_channel_waveform_inst
    (
        .i_clock(clock), .i_reset_n(reset_n), .i_clock_enable(ce),
        .i_divided_clock_a(div_a), .i_divided_clock_b(div_b),
        .i_period_value(per_val), .i_period_write(per_wr),
        .i_duty_value(duty_val), .i_duty_write(duty_wr),
        .i_channel_update_value(upd_val), .i_update_write(upd_wr),
        .i_mode_write(mode_wr), .i_alignment_select(align), .i_start_level_select(level),
        .i_update_target_select(target), .i_channel_clock_select(sel),
        .i_enable_write(en_wr), .i_disable_write(dis_wr),
        .i_irq_enable_write(ien_wr), .i_irq_disable_write(idis_wr),
        .o_pwm(pwm), .o_enabled(enabled), .o_irq_enabled(irq_on),
        .o_update_pending(pending), .o_counter(counter), .o_period_irq(irq)
    );

    pwm_load pwm_load_inst
    (
        .i_clock(clock), .i_pin(pwm), .i_clear(clr), .o_high_cycles(high_cycles)
    );

    // ------------------------------------------------------------
    // reference model, stepped once per clock
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        begin
            tests_run++;
            if (seen !== want)
            begin
                fails++;
                $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
            end
        end
    endtask

    // fixed levels first, then the duty point
    function automatic logic exp_pwm();
        if (!m_on || m_d == m_p)
            return m_lvl;
        if (m_d == 0)
            return ~m_lvl;
        return (m_cnt < m_p - m_d) ? m_lvl : ~m_lvl;
    endfunction

    task automatic step();
        bit tick;
        bit wrap;
        begin
            @(posedge clock);
            // prescaled tick every 2^sel cycles, divided ticks, else none
            if (m_sel <= SEL_PRESCALE_MAX)
                tick = (m_pre % (1 << m_sel)) == (1 << m_sel) - 1;
            else
                tick = (m_sel == SEL_DIVIDED_A && div_a) || (m_sel == SEL_DIVIDED_B && div_b);
            m_pre = m_pre + 1;
            wrap = 1'b0;
            if (m_on && tick)
            begin
                if (m_align == ALIGN_LEFT)
                begin
                    wrap = m_cnt >= m_p;
                    m_cnt = wrap ? 0 : m_cnt + 1;
                end
                else if (!m_dir)
                begin
                    // period 0 ends at once, period 1 turns straight into the end
                    wrap = m_p == 0;
                    m_dir = !wrap && m_cnt >= m_p;
                    m_cnt = wrap ? m_cnt : (m_dir ? m_cnt - 1 : m_cnt + 1);
                    if (m_dir && m_cnt == 0)
                    begin
                        wrap = 1'b1;
                        m_dir = 1'b0;
                    end
                end
                else
                begin
                    m_cnt = m_cnt - 1;
                    wrap = m_cnt == 0;
                    m_dir = !wrap;
                end
                if (wrap && m_irq)
                    irq_exp++;
                if (wrap && m_pend)
                begin
                    m_pend = 1'b0;
                    if (m_tgt == TARGET_PERIOD)
                        m_p = m_upd;
                    else
                        m_d = m_upd;
                end
            end
            if (upd_wr)
            begin
                m_pend = 1'b1;
                m_upd = upd_val;
            end
            // start level and direct loads only while disabled
            if (mode_wr)
            begin
                m_align = align;
                m_tgt = target;
                m_sel = sel;
                m_lvl = m_on ? m_lvl : level;
            end
            if (per_wr && !m_on)
                m_p = per_val;
            if (duty_wr && !m_on)
                m_d = duty_val;
            m_irq = ien_wr ? 1'b1 : (idis_wr ? 1'b0 : m_irq);
            if (en_wr && !m_on)
                m_pre = 0;
            if (dis_wr)
            begin
                m_on = 1'b0;
                m_pend = 1'b0;
            end
            else if (en_wr && !m_on)
            begin
                m_on = 1'b1;
                m_cnt = 0;
                m_dir = 1'b0;
            end
            if (clr)
                m_high = 0;
            @(negedge clock);
            {per_wr, duty_wr, upd_wr, mode_wr, en_wr, dis_wr, ien_wr, idis_wr, clr} = '0;
            {div_a, div_b} = '0;
            if (irq === 1'b1)
                irq_seen++;
            check(high_cycles, m_high);
            check({pwm, enabled, irq_on, pending}, {exp_pwm(), m_on, m_irq, m_pend});
            if (m_on)
                check(counter, m_cnt);
            m_high += exp_pwm();
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_wave(input logic al, lv, ie, md, input int p, d);
        begin
            // level (when md) and duty not above period set before enabling
            align = al;
            level = lv;
            per_val = 16'(p);
            duty_val = 16'(d);
            {mode_wr, per_wr, duty_wr, ien_wr, idis_wr, clr} = {md, 2'b11, ie, !ie, 1'b1};
            irq_seen = 0;
            irq_exp = 0;
            step();
            en_wr = 1'b1;
            repeat (4 * p + 14) step();
            dis_wr = 1'b1;
            repeat (3) step();
            check(irq_seen, irq_exp);
        end
    endtask

    task automatic t_level();
        begin
            {level, mode_wr, per_wr, duty_wr, per_val, duty_val} = {4'hf, 16'h5, 16'h2};
            step();
            en_wr = 1'b1;
            step();
            {level, mode_wr, per_wr, per_val} = {3'b011, 16'h9};
            repeat (14) step();
            dis_wr = 1'b1;
            repeat (2) step();
            check(pwm, 1'b1);
        end
    endtask

    task automatic t_update();
        begin
            {level, target, mode_wr, per_wr, duty_wr} = {TARGET_DUTY, 4'h7};
            {per_val, duty_val} = {16'h6, 16'h2};
            step();
            en_wr = 1'b1;
            repeat (3) step();
            {upd_wr, upd_val} = {1'b1, 16'h4};
            repeat (12) step();
            // back-to-back period updates keep period above duty
            {target, mode_wr, upd_wr, upd_val} = {TARGET_PERIOD, 2'b11, 16'h4};
            step();
            {upd_wr, upd_val} = {1'b1, 16'h5};
            repeat (20) step();
            {upd_wr, upd_val} = {1'b1, 16'h6};
            step();
            dis_wr = 1'b1;
            repeat (2) step();
        end
    endtask

    task automatic t_clock(input logic [3:0] s);
        begin
            {sel, target, mode_wr, per_wr, duty_wr} = {s, TARGET_DUTY, 3'b111};
            {per_val, duty_val} = {16'h3, 16'h1};
            step();
            en_wr = 1'b1;
            for (int i = 0; i < 40; i++)
            begin
                div_a = (i % 3) == 0;
                div_b = (i % 5) == 0;
                step();
            end
            {dis_wr, mode_wr, sel} = {2'b11, 4'h0};
            step();
        end
    endtask

    // clock enable low: counter and output stand still, load keeps counting high cycles
    task automatic t_freeze();
        begin
            en_wr = 1'b1;
            repeat (5) step();
            ce = 1'b0;
            repeat (6)
            begin
                @(negedge clock);
                check(counter, m_cnt);
                check(pwm, exp_pwm());
                check(high_cycles, m_high);
                m_high += exp_pwm();
            end
            ce = 1'b1;
            dis_wr = 1'b1;
            repeat (2) step();
        end
    endtask

    task automatic results();
        begin
            $display("comparisons %0d, mismatches %0d", tests_run, fails);
            if (fails == 0 && tests_run > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask

    initial
    begin
        #500000;
        fails++;
        results();
    end

    initial
    begin
        repeat (20) @(negedge clock);
        check({pwm, enabled, irq_on, pending, counter}, 20'h0);
        reset_n = 1'b1;
        t_wave(1'b0, 1'b0, 1'b1, 1'b0, 4, 1);
        t_wave(1'b1, 1'b0, 1'b1, 1'b1, 4, 1);
        t_wave(1'b0, 1'b1, 1'b0, 1'b1, 5, 2);
        t_wave(1'b1, 1'b1, 1'b1, 1'b1, 3, 1);
        t_wave(1'b0, 1'b0, 1'b0, 1'b1, 4, 4);
        t_wave(1'b0, 1'b1, 1'b0, 1'b1, 4, 0);
        t_wave(1'b0, 1'b0, 1'b1, 1'b1, 4, 0);
        t_wave(1'b1, 1'b1, 1'b0, 1'b1, 4, 4);
        t_wave(1'b1, 1'b0, 1'b1, 1'b1, 1, 0);
        t_wave(1'b0, 1'b0, 1'b1, 1'b1, 0, 0);
        t_level();
        t_update();
        t_clock(SEL_DIVIDED_A);
        t_clock(SEL_DIVIDED_B);
        t_clock(4'h2);
        t_clock(4'hd);
        t_freeze();
        results();
    end
endmodule
